// >>> acfic_pkg.sv
// constants for the activity, filter and interrupt configuration bank
package acfic_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_ACT_LIMIT_HIGH = 8'h25;
  localparam logic [7:0] ADDR_ACT_LIMIT_LOW = 8'h26;
  localparam logic [7:0] ADDR_ACT_RUN_LENGTH = 8'h27;
  localparam logic [7:0] ADDR_FILTER = 8'h28;
  localparam logic [7:0] ADDR_QUEUE_WM = 8'h29;
  localparam logic [7:0] ADDR_IRQ_ROUTING = 8'h2A;
  localparam logic [7:0] ADDR_TIMING_SYNC = 8'h2B;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_ACT_LIMIT_HIGH = 8'h00;
  localparam logic [7:0] RST_ACT_LIMIT_LOW = 8'h00;
  localparam logic [7:0] RST_ACT_RUN_LENGTH = 8'h01;
  localparam logic [2:0] RST_HP_CORNER = 3'h0;
  localparam logic [3:0] RST_RATE_LP = 4'h0;
  localparam logic [6:0] RST_QUEUE_WM = 7'h60;
  localparam logic [7:0] RST_IRQ_ROUTING = 8'h00;
  localparam logic [1:0] RST_TIMING_SEL = 2'h0;
  localparam logic RST_CLOCK_SEL = 1'b0;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int HP_CORNER_LSB = 4;
  localparam int RATE_LP_LSB = 0;
  localparam int CLOCK_SEL_BIT = 2;
  localparam int TIMING_SEL_LSB = 0;
  localparam int ROUTE_B_LSB = 4;
  localparam int ROUTE_A_LSB = 0;
  localparam int EVT_READY = 0;
  localparam int EVT_LEVEL = 1;
  localparam int EVT_OVERRUN = 2;
  localparam int EVT_ACTIVITY = 3;
  localparam int SAMPLE_LIMIT_LSB = 3;
  localparam int SAMPLE_LIMIT_MSB = 18;
  localparam logic [3:0] RATE_LP_MAX = 4'hA;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int OSC_HZ = 1_000_000;
  localparam int OSC_DIV_CYC = CLK_HZ / OSC_HZ;
  localparam int BASE_RATE_HZ = 4000;
  localparam int RATE_BASE_TICKS = OSC_HZ / BASE_RATE_HZ;
  localparam int INTERP_MIN_OSC = 8;
  localparam int INTERP_MAX_OSC = 4102;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TSEL_INTERNAL,
    TSEL_EXT_DIRECT,
    TSEL_EXT_INTERP,
    TSEL_RESERVED
  } acfic_tsel_type;
  typedef enum logic {
    SY_IDLE,
    SY_WAIT
  } acfic_sync_state_type;
endpackage

// >>> acfic_config_bank.sv
// activity detection, filter, queue watermark, interrupt routing and timing control bank
`timescale 1ns/1ps
// Notes on behaviour
// - activity counter advances only when sample magnitude strictly exceeds unsigned limit
// - limit aligns with sample bits 18..3; high byte 0x25, low byte 0x26
// - activity declared once consecutive above-limit count reaches run length, reset one
// - highpass corner code 000 disables filter; 001..110 give lower corners
// - rate code 0000 is 4000 Hz, each step through 1010 halves rate
// - level reached when stored count reaches watermark; host programs 1..96 only
// - watermark resets to 0x60 so default settings trigger it only once the count reaches 96
// - each irq pin ORs every event whose routing bit is set
// - pin b routing: bit7 activity, bit6 overrun, bit5 level, bit4 ready
// - pin a routing: bit3 activity, bit2 overrun, bit1 level, bit0 ready
// - timing select 00 uses internal timing; host never writes 11
// - select 01 skips interpolation, sample ready on each sync pulse
// - select 10 interpolates, ready 8..4102 oscillator ticks after sync
// - clock select bit 2 switches timing source to external clock input
// - axis joins activity evaluation only when its enable bit is set
// - host changes settings only in standby, except the highpass corner
// - irq pins active low when polarity bit is 0, high when 1
module acfic_config_bank
  import acfic_pkg::*;
#(
  parameter int RATE_TICKS = RATE_BASE_TICKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register access port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // controls kept elsewhere
  input wire logic standby,
  input wire logic irq_polarity,
  input wire logic activity_axis_x_on,
  input wire logic activity_axis_y_on,
  input wire logic activity_axis_z_on,
  // sample path
  input wire logic sample_valid,
  input wire logic [19:0] x_axis_sample,
  input wire logic [19:0] y_axis_sample,
  input wire logic [19:0] z_axis_sample,
  input wire logic ready_clear,
  // queue status
  input wire logic [6:0] queue_count,
  input wire logic queue_overrun,
  // external timing pins
  input wire logic external_timing_sel_pin,
  input wire logic external_clock_sel_pin,
  // filter and timing controls out
  output logic [2:0] highpass_corner_sel,
  output logic highpass_on_q,
  output logic [3:0] rate_lowpass_sel,
  output logic interp_on_q,
  output logic sample_ready_q,
  // events and pins
  output logic activity_q,
  output logic level_reached_q,
  output logic data_ready_q,
  output logic irq_pin_a_q,
  output logic irq_pin_b_q
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] act_limit_q;
  logic [7:0] run_length_q;
  logic [2:0] hp_corner_q;
  logic [3:0] rate_lp_q;
  logic [6:0] queue_wm_q;
  logic [7:0] irq_route_q;
  logic [1:0] timing_sel_q;
  logic external_clock_sel_q;

  assign highpass_corner_sel = hp_corner_q;
  assign rate_lowpass_sel = rate_lp_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_limit_q <= {RST_ACT_LIMIT_HIGH, RST_ACT_LIMIT_LOW};
      run_length_q <= RST_ACT_RUN_LENGTH;
      hp_corner_q <= RST_HP_CORNER;
      rate_lp_q <= RST_RATE_LP;
      queue_wm_q <= RST_QUEUE_WM;
      irq_route_q <= RST_IRQ_ROUTING;
      timing_sel_q <= RST_TIMING_SEL;
      external_clock_sel_q <= RST_CLOCK_SEL;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_ACT_LIMIT_HIGH: act_limit_q[15:8] <= reg_wdata;
        ADDR_ACT_LIMIT_LOW: act_limit_q[7:0] <= reg_wdata;
        ADDR_ACT_RUN_LENGTH: run_length_q <= reg_wdata;
        ADDR_FILTER: begin
          hp_corner_q <= reg_wdata[HP_CORNER_LSB +: 3];
          rate_lp_q <= reg_wdata[RATE_LP_LSB +: 4];
        end
        ADDR_QUEUE_WM: queue_wm_q <= reg_wdata[6:0];
        ADDR_IRQ_ROUTING: irq_route_q <= reg_wdata;
        ADDR_TIMING_SYNC: begin
          timing_sel_q <= reg_wdata[TIMING_SEL_LSB +: 2];
          external_clock_sel_q <= reg_wdata[CLOCK_SEL_BIT];
        end
        default: ;
      endcase
    end
  end

  // reserved bits and unmapped addresses read as zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_ACT_LIMIT_HIGH: reg_rdata_q <= act_limit_q[15:8];
        ADDR_ACT_LIMIT_LOW: reg_rdata_q <= act_limit_q[7:0];
        ADDR_ACT_RUN_LENGTH: reg_rdata_q <= run_length_q;
        ADDR_FILTER: reg_rdata_q <= {1'b0, hp_corner_q, rate_lp_q};
        ADDR_QUEUE_WM: reg_rdata_q <= {1'b0, queue_wm_q};
        ADDR_IRQ_ROUTING: reg_rdata_q <= irq_route_q;
        ADDR_TIMING_SYNC: reg_rdata_q <= {5'h00, external_clock_sel_q, timing_sel_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // filter decode
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      highpass_on_q <= 1'b0;
      interp_on_q <= 1'b0;
    end else begin
      highpass_on_q <= (hp_corner_q != 3'h0);
      interp_on_q <= (timing_sel_q == TSEL_EXT_INTERP);
    end
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync_sh_q;
  logic [2:0] eclk_sh_q;
  logic sync_rise;
  logic eclk_rise;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_sh_q <= 3'h0;
      eclk_sh_q <= 3'h0;
    end else begin
      sync_sh_q <= {sync_sh_q[1:0], external_timing_sel_pin};
      eclk_sh_q <= {eclk_sh_q[1:0], external_clock_sel_pin};
    end
  end
  assign sync_rise = sync_sh_q[1] & ~sync_sh_q[2];
  assign eclk_rise = eclk_sh_q[1] & ~eclk_sh_q[2];

  // ------------------------------------------------------------
  // timing source
  // ------------------------------------------------------------
  localparam logic [7:0] OSC_DIV_LAST = 8'(OSC_DIV_CYC - 1);
  logic [7:0] osc_div_q;
  logic osc_int;
  logic osc_tick;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_div_q <= 8'h00;
    end else if (osc_div_q == OSC_DIV_LAST) begin
      osc_div_q <= 8'h00;
    end else begin
      osc_div_q <= osc_div_q + 8'h01;
    end
  end
  assign osc_int = (osc_div_q == OSC_DIV_LAST);
  assign osc_tick = external_clock_sel_q ? eclk_rise : osc_int;

  // ------------------------------------------------------------
  // sample timing
  // ------------------------------------------------------------
  function automatic logic [12:0] interp_delay(input logic [3:0] code);
    int d;
    d = INTERP_MIN_OSC + ((INTERP_MAX_OSC - INTERP_MIN_OSC) * int'(code)) / int'(RATE_LP_MAX);
    return 13'(d);
  endfunction

  logic [31:0] rate_cnt_q;
  logic [31:0] rate_period;
  logic [12:0] wait_cnt_q;
  acfic_sync_state_type sy_state_q;
  logic rate_hit;
  logic wait_done;

  assign rate_period = 32'(RATE_TICKS) << rate_lp_q;
  assign rate_hit = osc_tick && (rate_cnt_q >= rate_period - 32'h1);
  assign wait_done = (sy_state_q == SY_WAIT) && osc_tick && (wait_cnt_q <= 13'h1);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rate_cnt_q <= 32'h0;
    end else if (standby || timing_sel_q == TSEL_EXT_DIRECT
                 || timing_sel_q == TSEL_EXT_INTERP) begin
      rate_cnt_q <= 32'h0;
    end else if (rate_hit) begin
      rate_cnt_q <= 32'h0;
    end else if (osc_tick) begin
      rate_cnt_q <= rate_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sy_state_q <= SY_IDLE;
      wait_cnt_q <= 13'h0;
    end else if (standby || timing_sel_q != TSEL_EXT_INTERP) begin
      sy_state_q <= SY_IDLE;
      wait_cnt_q <= 13'h0;
    end else begin
      case (sy_state_q)
        SY_IDLE: begin
          if (sync_rise) begin
            sy_state_q <= SY_WAIT;
            wait_cnt_q <= interp_delay(rate_lp_q);
          end
        end
        SY_WAIT: begin
          if (wait_done) begin
            sy_state_q <= SY_IDLE;
          end else if (osc_tick) begin
            wait_cnt_q <= wait_cnt_q - 13'h1;
          end
        end
        default: sy_state_q <= SY_IDLE;
      endcase
    end
  end

  // reserved code 11 falls back to internal timing
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_ready_q <= 1'b0;
    end else if (standby) begin
      sample_ready_q <= 1'b0;
    end else begin
      case (timing_sel_q)
        TSEL_EXT_DIRECT: sample_ready_q <= sync_rise;
        TSEL_EXT_INTERP: sample_ready_q <= wait_done;
        default: sample_ready_q <= rate_hit;
      endcase
    end
  end

  // ------------------------------------------------------------
  // activity detection
  // ------------------------------------------------------------
  logic [2:0] axis_on;
  logic [2:0] axis_above;
  logic [19:0] axis_val [3];
  logic above;
  logic [7:0] run_q;
  logic [7:0] run_next;

  assign axis_on = {activity_axis_z_on, activity_axis_y_on, activity_axis_x_on};
  assign axis_val[0] = x_axis_sample;
  assign axis_val[1] = y_axis_sample;
  assign axis_val[2] = z_axis_sample;

  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic [19:0] mag;
    assign mag = axis_val[i][19] ? 20'(~axis_val[i] + 20'h1) : axis_val[i];
    assign axis_above[i] = axis_on[i]
      && (mag[19:SAMPLE_LIMIT_LSB] > {1'b0, act_limit_q});
  end
  assign above = |axis_above;
  assign run_next = (run_q == 8'hFF) ? run_q : run_q + 8'h01;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= 8'h00;
      activity_q <= 1'b0;
    end else if (standby) begin
      run_q <= 8'h00;
      activity_q <= 1'b0;
    end else if (sample_valid) begin
      if (above) begin
        run_q <= run_next;
        activity_q <= (run_next >= run_length_q);
      end else begin
        run_q <= 8'h00;
        activity_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // queue level and ready flag
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_reached_q <= 1'b0;
      data_ready_q <= 1'b0;
    end else begin
      level_reached_q <= ~standby && (queue_count >= queue_wm_q);
      if (sample_ready_q) begin
        data_ready_q <= 1'b1;
      end else if (ready_clear || standby) begin
        data_ready_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt pins
  // ------------------------------------------------------------
  logic [3:0] events;
  logic any_a;
  logic any_b;

  assign events = {activity_q, queue_overrun, level_reached_q, data_ready_q};
  assign any_a = |(events & irq_route_q[ROUTE_A_LSB +: 4]);
  assign any_b = |(events & irq_route_q[ROUTE_B_LSB +: 4]);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_pin_a_q <= 1'b1;
      irq_pin_b_q <= 1'b1;
    end else begin
      irq_pin_a_q <= irq_polarity ? any_a : ~any_a;
      irq_pin_b_q <= irq_polarity ? any_b : ~any_b;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_run_clears: assert property (
    sample_valid && !standby && !above |=> run_q == 8'h00 && !activity_q)
    else $error("run counter not cleared below limit");

  a_activity_len: assert property (
    activity_q |-> run_q >= run_length_q)
    else $error("activity declared before run length");

  a_run_advance: assert property (
    sample_valid && !standby && above && run_q != 8'hFF |=> run_q == $past(run_q) + 8'h01)
    else $error("run counter did not advance");

  a_level_cmp: assert property (
    !standby && queue_count >= queue_wm_q |=> level_reached_q)
    else $error("queue level not raised");

  a_direct_sync: assert property (
    !standby && timing_sel_q == TSEL_EXT_DIRECT && sync_rise |=> sample_ready_q)
    else $error("direct sync did not give sample ready");

  a_interp_min: assert property (
    sy_state_q == SY_IDLE && timing_sel_q == TSEL_EXT_INTERP && sync_rise && !standby
    |=> !sample_ready_q [*8])
    else $error("interpolated ready too early");

  a_ext_clock_src: assert property (
    external_clock_sel_q && !eclk_rise && !standby && timing_sel_q == TSEL_INTERNAL
    |=> $stable(rate_cnt_q))
    else $error("timing advanced without external clock");

  a_pin_a_route: assert property (
    irq_route_q[ROUTE_A_LSB + EVT_ACTIVITY] && activity_q
    |=> irq_pin_a_q == $past(irq_polarity))
    else $error("activity not shown on pin a");

  a_pin_b_route: assert property (
    irq_route_q[ROUTE_B_LSB + EVT_READY] && data_ready_q
    |=> irq_pin_b_q == $past(irq_polarity))
    else $error("ready not shown on pin b");

  a_hp_off: assert property (
    hp_corner_q == 3'h0 |=> !highpass_on_q)
    else $error("highpass enabled with code zero");

  c_activity: cover property ($rose(activity_q));
  c_interp: cover property (wait_done ##1 sample_ready_q);
  c_internal: cover property (timing_sel_q == TSEL_INTERNAL && sample_ready_q);
  c_both_pins: cover property (any_a && any_b);
endmodule

// >>> acfic_host_model.sv
// host model driving the register port of the configuration bank
`timescale 1ns/1ps
module acfic_host_model
  import acfic_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // operating mode
  output logic standby
);
  // last rate field written; only a corner-only change may skip standby
  logic [3:0] rate_shadow;
  initial begin
    rate_shadow = RST_RATE_LP;
    reg_addr = 8'h00;
    reg_wdata = 8'hFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    standby = 1'b1;
  end
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic set_standby(input logic s);
    @(posedge ref_clk);
    #1;
    standby = s;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ADDR_QUEUE_WM && (v[6:0] == 7'h00 || v[6:0] > 7'h60)) v[6:0] = 7'h60;
    if (a == ADDR_TIMING_SYNC && v[1:0] == 2'b11) v[1:0] = 2'b00;
    if (a != ADDR_FILTER || v[3:0] != rate_shadow) set_standby(1'b1);
    if (a == ADDR_FILTER) rate_shadow = v[3:0];
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_q;
  endtask
endmodule

// >>> tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ps
module tb;
  import acfic_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int RT = 2;
  logic ref_clk = 1'b0;
  logic sys_rst;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic reg_wr, reg_rd, standby;
  logic irq_polarity;
  logic activity_axis_x_on, activity_axis_y_on, activity_axis_z_on;
  logic sample_valid, ready_clear, queue_overrun;
  logic external_timing_sel_pin, external_clock_sel_pin;
  logic [19:0] x_axis_sample, y_axis_sample;
  logic [19:0] z_axis_sample;
  logic [6:0] queue_count;
  logic [2:0] highpass_corner_sel;
  logic [3:0] rate_lowpass_sel;
  logic highpass_on_q, interp_on_q, sample_ready_q, activity_q, level_reached_q;
  logic data_ready_q, irq_pin_a_q, irq_pin_b_q;
  logic seen = 1'b0;
  logic [3:0] ev = 4'b0110;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00};
  logic [7:0] d;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  // ------------------------------------------------------------
  // design and host
  // ------------------------------------------------------------
  acfic_config_bank #(.RATE_TICKS(RT)) u_dut (
    .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .standby, .irq_polarity, .activity_axis_x_on, .activity_axis_y_on,
    .activity_axis_z_on, .sample_valid, .x_axis_sample, .y_axis_sample,
    .z_axis_sample, .ready_clear, .queue_count, .queue_overrun, .external_timing_sel_pin,
    .external_clock_sel_pin, .highpass_corner_sel, .highpass_on_q, .rate_lowpass_sel,
    .interp_on_q, .sample_ready_q, .activity_q, .level_reached_q, .data_ready_q,
    .irq_pin_a_q, .irq_pin_b_q
  );
  acfic_host_model u_host (
    .ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .standby
  );
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (sample_ready_q === 1'b1) seen <= 1'b1;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wready(input int lim, output int cnt);
    cnt = 0;
    do begin
      step(1);
      cnt++;
    end while (sample_ready_q !== 1'b1 && cnt < lim);
    if (cnt >= lim) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      close_out();
    end
  endtask
  task automatic smp(input logic [19:0] x, input logic [19:0] y);
    x_axis_sample = x;
    y_axis_sample = y;
    sample_valid = 1'b1;
    step(1);
    sample_valid = 1'b0;
    x_axis_sample = ~x;
    y_axis_sample = ~y;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    irq_polarity = 1'b0;
    {activity_axis_x_on, activity_axis_y_on, activity_axis_z_on} = 3'b000;
    {sample_valid, ready_clear, queue_overrun} = 3'b000;
    {external_timing_sel_pin, external_clock_sel_pin} = 2'b00;
    x_axis_sample = 20'h00000;
    y_axis_sample = 20'h00000;
    z_axis_sample = 20'h00000;
    queue_count = 7'h00;
    step(3);
    sys_rst = 1'b0;
    chk({irq_pin_b_q, irq_pin_a_q}, 2'b11);
    u_host.wr(8'h2C, 8'h5A);
    for (int i = 0; i < 8; i++) begin
      u_host.rd(8'h25 + i[7:0], d);
      chk(d, rst_tab[i]);
    end
    done("reset");
    u_host.wr(ADDR_FILTER, 8'hE5);
    u_host.rd(ADDR_FILTER, d);
    chk(d, 8'h65);
    chk({highpass_corner_sel, rate_lowpass_sel}, 7'h65);
    for (int c = 0; c < 7; c++) begin
      u_host.wr(ADDR_FILTER, {1'b0, c[2:0], 4'h0});
      step(1);
      chk({highpass_on_q, highpass_corner_sel}, {c != 0, c[2:0]});
    end
    u_host.wr(ADDR_QUEUE_WM, 8'h85);
    u_host.rd(ADDR_QUEUE_WM, d);
    chk(d, 8'h05);
    u_host.wr(ADDR_TIMING_SYNC, 8'hFE);
    u_host.rd(ADDR_TIMING_SYNC, d);
    chk({d, interp_on_q}, {8'h06, 1'b1});
    done("fields");
    irq_polarity = 1'b1;
    activity_axis_x_on = 1'b1;
    u_host.wr(ADDR_ACT_LIMIT_HIGH, 8'h01);
    u_host.wr(ADDR_ACT_LIMIT_LOW, 8'h10);
    u_host.wr(ADDR_ACT_RUN_LENGTH, 8'h02);
    u_host.wr(ADDR_IRQ_ROUTING, 8'h08);
    u_host.set_standby(1'b0);
    smp(20'h00888, 20'h00000);
    chk(activity_q, 1'b0);
    smp(20'h00880, 20'h00000);
    smp(20'h00888, 20'h00000);
    chk(activity_q, 1'b0);
    smp(20'hFF778, 20'h00000);
    chk(activity_q, 1'b1);
    step(1);
    chk({irq_pin_b_q, irq_pin_a_q}, 2'b01);
    smp(20'h00000, 20'h00888);
    chk(activity_q, 1'b0);
    activity_axis_y_on = 1'b1;
    smp(20'h00000, 20'h00888);
    smp(20'h00000, 20'h00888);
    chk(activity_q, 1'b1);
    activity_axis_y_on = 1'b0;
    activity_axis_z_on = 1'b1;
    smp(20'h00000, 20'h00888);
    chk(activity_q, 1'b0);
    z_axis_sample = 20'hFF778;
    smp(20'h00000, 20'h00000);
    smp(20'h00000, 20'h00000);
    chk(activity_q, 1'b1);
    done("activity");
    irq_polarity = 1'b0;
    u_host.wr(ADDR_QUEUE_WM, 8'h05);
    queue_count = 7'h04;
    u_host.set_standby(1'b0);
    step(2);
    chk(level_reached_q, 1'b0);
    queue_count = 7'h05;
    queue_overrun = 1'b1;
    step(2);
    chk(level_reached_q, 1'b1);
    for (int b = 0; b < 8; b++) begin
      u_host.wr(ADDR_IRQ_ROUTING, 8'h01 << b);
      u_host.set_standby(1'b0);
      step(3);
      chk({irq_pin_b_q, irq_pin_a_q}, 2'(~({b >= 4, b < 4} & {2{ev[b % 4]}})));
    end
    u_host.wr(ADDR_IRQ_ROUTING, 8'hFF);
    u_host.set_standby(1'b0);
    step(3);
    chk({irq_pin_b_q, irq_pin_a_q}, 2'b00);
    irq_polarity = 1'b1;
    step(2);
    chk({irq_pin_b_q, irq_pin_a_q}, 2'b11);
    queue_overrun = 1'b0;
    queue_count = 7'h00;
    done("routing");
    u_host.wr(ADDR_TIMING_SYNC, 8'h01);
    u_host.wr(ADDR_IRQ_ROUTING, 8'h11);
    u_host.set_standby(1'b0);
    external_timing_sel_pin = 1'b1;
    wready(10, n);
    chk(n <= 5, 1'b1);
    step(1);
    chk(data_ready_q, 1'b1);
    step(1);
    chk({irq_pin_b_q, irq_pin_a_q}, 2'b11);
    ready_clear = 1'b1;
    step(1);
    ready_clear = 1'b0;
    chk(data_ready_q, 1'b0);
    external_timing_sel_pin = 1'b0;
    u_host.wr(ADDR_TIMING_SYNC, 8'h02);
    u_host.wr(ADDR_FILTER, 8'h00);
    u_host.set_standby(1'b0);
    external_timing_sel_pin = 1'b1;
    wready(3000, n);
    chk(n >= 7 * OSC_DIV_CYC && n <= 9 * OSC_DIV_CYC + 10, 1'b1);
    external_timing_sel_pin = 1'b0;
    for (int c = 0; c < 3; c++) begin
      u_host.wr(ADDR_FILTER, 8'(c));
      u_host.wr(ADDR_TIMING_SYNC, 8'h00);
      u_host.set_standby(1'b0);
      wready(5000, n);
      wready(5000, n);
      chk(n, (RT << c) * OSC_DIV_CYC);
    end
    chk(interp_on_q, 1'b0);
    u_host.wr(ADDR_TIMING_SYNC, 8'h04);
    u_host.set_standby(1'b0);
    seen = 1'b0;
    step(1200);
    chk(seen, 1'b0);
    repeat (10) begin
      external_clock_sel_pin = 1'b1;
      step(10);
      external_clock_sel_pin = 1'b0;
      step(10);
    end
    chk(seen, 1'b1);
    done("timing");
    close_out();
  end
endmodule
